// >>> hdl/psc_pkg.sv
// Package: register map, field layout, timing and types of the config block
package psc_pkg;

	// Register offsets on the control bus
	localparam logic [7:0] PSC_OFS_SWRST = 8'h01;
	localparam logic [7:0] PSC_OFS_SLEEP = 8'h02;
	localparam logic [7:0] PSC_OFS_SHDN = 8'h05;
	localparam logic [7:0] PSC_OFS_SERIAL = 8'h07;

	// Values after reset
	localparam logic [7:0] PSC_RST_SLEEP = 8'h00;
	localparam logic [7:0] PSC_RST_SHDN = 8'h05;
	localparam logic [7:0] PSC_RST_SERIAL = 8'h30;
	localparam logic [7:0] PSC_RST_ZERO = 8'h00;

	// Writable bits; the rest hold their reset value
	localparam logic [7:0] PSC_WMASK_SLEEP = 8'hFD;
	localparam logic [7:0] PSC_WMASK_SHDN = 8'h3F;

	// Field positions
	localparam int PSC_BIT_SUPPLY = 7;
	localparam int PSC_POS_REFQ = 3;
	localparam int PSC_BIT_BCAST = 2;
	localparam int PSC_BIT_WAKE = 0;
	localparam int PSC_POS_INCAPQ = 4;
	localparam int PSC_POS_FMT = 6;
	localparam int PSC_BIT_SWRST = 0;

	// Protocol codes
	localparam logic [1:0] PSC_FMT_TDM = 2'h0;
	localparam logic [1:0] PSC_FMT_I2S = 2'h1;
	localparam logic [1:0] PSC_FMT_RESERVED = 2'h3;

	// Fixed broadcast target address
	localparam logic [6:0] PSC_BCAST_ADDR = 7'h4C;

	// Clock and quick-charge durations
	localparam real PSC_CLK_PERIOD_NS = 5.0;
	localparam real PSC_REF_QCHG_MS0 = 3.5;
	localparam real PSC_REF_QCHG_MS1 = 10.0;
	localparam real PSC_REF_QCHG_MS2 = 50.0;
	localparam real PSC_REF_QCHG_MS3 = 100.0;
	localparam real PSC_INPUT_CAP_FAST_CHARGE_TIME_MS0 = 2.5;
	localparam real PSC_INPUT_CAP_FAST_CHARGE_TIME_MS1 = 12.5;
	localparam real PSC_INPUT_CAP_FAST_CHARGE_TIME_MS2 = 25.0;
	localparam real PSC_INPUT_CAP_FAST_CHARGE_TIME_MS3 = 50.0;
	localparam int PSC_QCHG_W = 25;
	localparam int PSC_REF_CYC0 = int'(PSC_REF_QCHG_MS0 * 1.0e6 / PSC_CLK_PERIOD_NS);
	localparam int PSC_REF_CYC1 = int'(PSC_REF_QCHG_MS1 * 1.0e6 / PSC_CLK_PERIOD_NS);
	localparam int PSC_REF_CYC2 = int'(PSC_REF_QCHG_MS2 * 1.0e6 / PSC_CLK_PERIOD_NS);
	localparam int PSC_REF_CYC3 = int'(PSC_REF_QCHG_MS3 * 1.0e6 / PSC_CLK_PERIOD_NS);
	localparam int PSC_INCAP_CYC0 = int'(PSC_INPUT_CAP_FAST_CHARGE_TIME_MS0 * 1.0e6 / PSC_CLK_PERIOD_NS);
	localparam int PSC_INCAP_CYC1 = int'(PSC_INPUT_CAP_FAST_CHARGE_TIME_MS1 * 1.0e6 / PSC_CLK_PERIOD_NS);
	localparam int PSC_INCAP_CYC2 = int'(PSC_INPUT_CAP_FAST_CHARGE_TIME_MS2 * 1.0e6 / PSC_CLK_PERIOD_NS);
	localparam int PSC_INCAP_CYC3 = int'(PSC_INPUT_CAP_FAST_CHARGE_TIME_MS3 * 1.0e6 / PSC_CLK_PERIOD_NS);

	// Serial config, laid out exactly as its register
	typedef struct packed {
		logic [1:0] serial_protocol_select;
		logic [1:0] slot_word_length;
		logic frame_sync_invert;
		logic bit_clock_invert;
		logic tx_edge_late;
		logic fill_high_z;
	} psc_serial_cfg_t;

	// Power controls decoded for the analog side
	typedef struct packed {
		logic analog_supply_select;
		logic [1:0] reference_fast_charge_time;
		logic broadcast_address_enable;
		logic wake_not_sleep;
		logic [1:0] input_cap_fast_charge_time;
	} psc_power_cfg_t;

	// Control bus target states, Gray along the write path
	typedef enum logic [2:0] {
		PSC_IDLE = 3'h0,
		PSC_ADDR = 3'h1,
		PSC_ADDR_ACK = 3'h3,
		PSC_WR_BYTE = 3'h2,
		PSC_WR_ACK = 3'h6,
		PSC_RD_BYTE = 3'h7,
		PSC_RD_ACK = 3'h5
	} psc_bus_state_t;

	// Slot length in bit cycles
	function automatic logic [6:0] psc_slot_len(input logic [1:0] code);
		unique case (code)
			2'h0: psc_slot_len = 7'h10;
			2'h1: psc_slot_len = 7'h14;
			2'h2: psc_slot_len = 7'h18;
			2'h3: psc_slot_len = 7'h20;
		endcase
	endfunction : psc_slot_len

endpackage : psc_pkg

// >>> hdl/psc_serial_tx.sv
// Audio serial port data lanes, target mode, clocked by the sampled bit clock
`timescale 1ns/1ps
module psc_serial_tx
	import psc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input psc_serial_cfg_t cfg,
	input wire logic wake,
	input wire logic bit_clock_pin,
	input wire logic frame_sync_pin,
	input wire logic [3:0][31:0] slot_words,
	output logic [1:0] data_o,
	output logic [1:0] data_oe
);

	typedef struct packed {
		logic bc_s1;
		logic bc_s2;
		logic bc_s3;
		logic fs_s1;
		logic fs_s2;
		logic fs_seen;
		logic half;
		logic [6:0] cnt;
		logic [1:0] out_bits;
		logic out_valid;
	} psc_tx_state_t;

	psc_tx_state_t s_q;
	psc_tx_state_t s_d;
	logic [6:0] len;
	logic [6:0] pos;
	logic slot;
	logic valid;
	logic [4:0] idx;
	logic [1:0] lane_bit;

	//////////////////////////////////////////////////////////////////////
	// Position decode from the registered count; cnt 0 is a lead bit
	assign len = psc_slot_len(cfg.slot_word_length);
	assign pos = s_q.cnt - 7'h01;
	always_comb begin
		slot = s_q.half;
		valid = 1'b0;
		idx = 5'h00;
		if (s_q.cnt != 7'h00) begin
			if (pos < len) begin
				valid = 1'b1;
				idx = 5'(pos);
			end else if (cfg.serial_protocol_select == PSC_FMT_TDM && pos < (len << 1)) begin
				valid = 1'b1;
				slot = 1'b1;
				idx = 5'(pos - len);
			end
		end
	end

	// Each lane carries its own pair of words, MSB first
	for (genvar g = 0; g < 2; g++) begin : g_lane
		assign lane_bit[g] = slot_words[{1'(g), slot}][5'h1F - idx];
	end

	//////////////////////////////////////////////////////////////////////
	// Edge finding and bit launch
	always_comb begin
		logic b_now;
		logic b_old;
		logic f;
		logic e_rise;
		logic e_fall;
		b_now = s_q.bc_s2 ^ cfg.bit_clock_invert;
		b_old = s_q.bc_s3 ^ cfg.bit_clock_invert;
		f = s_q.fs_s2 ^ cfg.frame_sync_invert;
		e_rise = b_now & ~b_old;
		e_fall = ~b_now & b_old;
		s_d = s_q;
		s_d.bc_s1 = bit_clock_pin;
		s_d.bc_s2 = s_q.bc_s1;
		s_d.bc_s3 = s_q.bc_s2;
		s_d.fs_s1 = frame_sync_pin;
		s_d.fs_s2 = s_q.fs_s1;
		// Frame sync sampled on the capture edge; I2S carries one lead bit
		if (e_rise) begin
			s_d.fs_seen = f;
			if (s_q.cnt != 7'h7F) begin
				s_d.cnt = s_q.cnt + 7'h01;
			end
			if (f != s_q.fs_seen) begin
				if (cfg.serial_protocol_select == PSC_FMT_I2S) begin
					s_d.half = f;
					s_d.cnt = 7'h00;
				end else if (f || cfg.serial_protocol_select != PSC_FMT_TDM) begin
					s_d.half = ~f;
					s_d.cnt = 7'h01;
				end
			end
		end
		// Launch on the opposite edge, or half a cycle later when asked
		if (cfg.tx_edge_late ? e_rise : e_fall) begin
			s_d.out_bits = lane_bit;
			s_d.out_valid = valid;
		end
		// Format may move under us; sleep parks the frame
		if (!wake) begin
			s_d.cnt = 7'h00;
			s_d.out_valid = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Unused cycles drive zero or float, for both lanes alike
	assign data_o = s_q.out_bits & {2{s_q.out_valid}};
	assign data_oe = {2{wake & (s_q.out_valid | ~cfg.fill_high_z)}};

endmodule : psc_serial_tx

// >>> hdl/psc_config_top.sv
// Power and serial format configuration registers behind the control bus
`timescale 1ns/1ps
module psc_config_top
	import psc_pkg::*;
#(
	parameter logic [6:0] DEVICE_ADDR = 7'h48, // Arbitrary own target address
	parameter logic [PSC_QCHG_W-1:0] REF_CYC0 = PSC_QCHG_W'(PSC_REF_CYC0),
	parameter logic [PSC_QCHG_W-1:0] REF_CYC1 = PSC_QCHG_W'(PSC_REF_CYC1),
	parameter logic [PSC_QCHG_W-1:0] REF_CYC2 = PSC_QCHG_W'(PSC_REF_CYC2),
	parameter logic [PSC_QCHG_W-1:0] REF_CYC3 = PSC_QCHG_W'(PSC_REF_CYC3),
	parameter logic [PSC_QCHG_W-1:0] INCAP_CYC0 = PSC_QCHG_W'(PSC_INCAP_CYC0),
	parameter logic [PSC_QCHG_W-1:0] INCAP_CYC1 = PSC_QCHG_W'(PSC_INCAP_CYC1),
	parameter logic [PSC_QCHG_W-1:0] INCAP_CYC2 = PSC_QCHG_W'(PSC_INCAP_CYC2),
	parameter logic [PSC_QCHG_W-1:0] INCAP_CYC3 = PSC_QCHG_W'(PSC_INCAP_CYC3)
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output psc_power_cfg_t power_cfg,
	output psc_serial_cfg_t serial_cfg,
	output logic ref_charge_active,
	output logic input_cap_charge_active,
	input wire logic bit_clock_pin,
	input wire logic frame_sync_pin,
	input wire logic [3:0][31:0] slot_words,
	output logic [1:0] serial_data_o,
	output logic [1:0] serial_data_oe
);

	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_s3;
		logic sda_s1;
		logic sda_s2;
		logic sda_s3;
		psc_bus_state_t st;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] txreg;
		logic [7:0] ptr;
		logic first;
		logic rd_mode;
		logic sda_drive;
		logic sw_reset;
		logic wake_old;
		logic [7:0] sleep_r;
		logic [7:0] shdn_r;
		logic [7:0] serial_r;
		logic [PSC_QCHG_W-1:0] ref_cnt;
		logic [PSC_QCHG_W-1:0] incap_cnt;
	} psc_top_state_t;

	psc_top_state_t s_q;
	psc_top_state_t s_d;

	//////////////////////////////////////////////////////////////////////
	// Read-back view; unmapped offsets and the reset trigger read zero
	function automatic logic [7:0] read_reg(input psc_top_state_t s, input logic [7:0] a);
		case (a)
			PSC_OFS_SLEEP: read_reg = s.sleep_r;
			PSC_OFS_SHDN: read_reg = s.shdn_r;
			PSC_OFS_SERIAL: read_reg = s.serial_r;
			default: read_reg = PSC_RST_ZERO;
		endcase
	endfunction : read_reg

	// Quick-charge lengths by code
	function automatic logic [PSC_QCHG_W-1:0] ref_len(input logic [1:0] c);
		unique case (c)
			2'h0: ref_len = REF_CYC0;
			2'h1: ref_len = REF_CYC1;
			2'h2: ref_len = REF_CYC2;
			2'h3: ref_len = REF_CYC3;
		endcase
	endfunction : ref_len

	function automatic logic [PSC_QCHG_W-1:0] incap_len(input logic [1:0] c);
		unique case (c)
			2'h0: incap_len = INCAP_CYC0;
			2'h1: incap_len = INCAP_CYC1;
			2'h2: incap_len = INCAP_CYC2;
			2'h3: incap_len = INCAP_CYC3;
		endcase
	endfunction : incap_len

	//////////////////////////////////////////////////////////////////////
	// Next-state logic: bus target, register writes, charge timers
	always_comb begin
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic hit;
		logic [7:0] wd;
		logic [7:0] rv;
		rise = s_q.scl_s2 & ~s_q.scl_s3;
		fall = ~s_q.scl_s2 & s_q.scl_s3;
		start = s_q.scl_s2 & s_q.scl_s3 & s_q.sda_s3 & ~s_q.sda_s2;
		stop = s_q.scl_s2 & s_q.scl_s3 & ~s_q.sda_s3 & s_q.sda_s2;
		hit = (s_q.shreg[7:1] == DEVICE_ADDR) ||
			(s_q.sleep_r[PSC_BIT_BCAST] && s_q.shreg[7:1] == PSC_BCAST_ADDR);
		wd = s_q.shreg;
		rv = read_reg(s_q, s_q.ptr);
		s_d = s_q;
		// Bus pins pass two flops before anything looks at them
		s_d.scl_s1 = scl_i;
		s_d.scl_s2 = s_q.scl_s1;
		s_d.scl_s3 = s_q.scl_s2;
		s_d.sda_s1 = sda_i;
		s_d.sda_s2 = s_q.sda_s1;
		s_d.sda_s3 = s_q.sda_s2;
		s_d.sw_reset = 1'b0;
		if (rise) begin
			s_d.shreg = {s_q.shreg[6:0], s_q.sda_s2};
			s_d.bitcnt = s_q.bitcnt + 4'h1;
		end
		unique case (s_q.st)
			PSC_IDLE: begin
				s_d.sda_drive = 1'b0;
			end
			PSC_ADDR: begin
				// Pull ack low after the eighth bit only when addressed
				if (fall && s_q.bitcnt == 4'h8) begin
					if (hit) begin
						s_d.st = PSC_ADDR_ACK;
						s_d.rd_mode = s_q.shreg[0];
						s_d.sda_drive = 1'b1;
					end else begin
						s_d.st = PSC_IDLE;
					end
				end
			end
			PSC_ADDR_ACK: begin
				if (fall) begin
					s_d.bitcnt = 4'h0;
					s_d.first = 1'b1;
					if (s_q.rd_mode) begin
						s_d.st = PSC_RD_BYTE;
						s_d.txreg = rv;
						s_d.sda_drive = ~rv[7];
					end else begin
						s_d.st = PSC_WR_BYTE;
						s_d.sda_drive = 1'b0;
					end
				end
			end
			PSC_WR_BYTE: begin
				if (fall && s_q.bitcnt == 4'h8) begin
					s_d.st = PSC_WR_ACK;
					s_d.sda_drive = 1'b1;
					s_d.first = 1'b0;
					if (s_q.first) begin
						s_d.ptr = wd;
					end else begin
						s_d.ptr = s_q.ptr + 8'h01;
						// Read-only bits keep reset value whatever is written
						case (s_q.ptr)
							PSC_OFS_SWRST: s_d.sw_reset = wd[PSC_BIT_SWRST];
							PSC_OFS_SLEEP: s_d.sleep_r = (wd & PSC_WMASK_SLEEP) |
								(PSC_RST_SLEEP & ~PSC_WMASK_SLEEP);
							PSC_OFS_SHDN: s_d.shdn_r = (wd & PSC_WMASK_SHDN) |
								(PSC_RST_SHDN & ~PSC_WMASK_SHDN);
							PSC_OFS_SERIAL: begin
								s_d.serial_r = wd;
								// Reserved format code leaves the protocol as it was
								if (wd[7:6] == PSC_FMT_RESERVED) begin
									s_d.serial_r[7:6] = s_q.serial_r[7:6];
								end
							end
							default: ;
						endcase
					end
				end
			end
			PSC_WR_ACK: begin
				if (fall) begin
					s_d.st = PSC_WR_BYTE;
					s_d.sda_drive = 1'b0;
					s_d.bitcnt = 4'h0;
				end
			end
			PSC_RD_BYTE: begin
				if (fall && s_q.bitcnt == 4'h8) begin
					s_d.st = PSC_RD_ACK;
					s_d.sda_drive = 1'b0;
					s_d.ptr = s_q.ptr + 8'h01;
				end else if (fall) begin
					s_d.txreg = {s_q.txreg[6:0], 1'b0};
					s_d.sda_drive = ~s_q.txreg[6];
				end
			end
			PSC_RD_ACK: begin
				// A high ack bit from the host ends the read
				if (fall && s_q.shreg[0]) begin
					s_d.st = PSC_IDLE;
				end else if (fall) begin
					s_d.st = PSC_RD_BYTE;
					s_d.bitcnt = 4'h0;
					s_d.txreg = rv;
					s_d.sda_drive = ~rv[7];
				end
			end
			default: begin
				s_d.st = PSC_IDLE;
				s_d.sda_drive = 1'b0;
			end
		endcase
		// Start and stop override any byte in flight
		if (start) begin
			s_d.st = PSC_ADDR;
			s_d.bitcnt = 4'h0;
			s_d.sda_drive = 1'b0;
		end else if (stop) begin
			s_d.st = PSC_IDLE;
			s_d.sda_drive = 1'b0;
		end
		// Quick charge runs from each wake; sleep cuts it short
		s_d.wake_old = s_q.sleep_r[PSC_BIT_WAKE];
		if (s_q.ref_cnt != '0) begin
			s_d.ref_cnt = s_q.ref_cnt - PSC_QCHG_W'(1);
		end
		if (s_q.incap_cnt != '0) begin
			s_d.incap_cnt = s_q.incap_cnt - PSC_QCHG_W'(1);
		end
		if (s_q.sleep_r[PSC_BIT_WAKE] && !s_q.wake_old) begin
			s_d.ref_cnt = ref_len(s_q.sleep_r[PSC_POS_REFQ+:2]);
			s_d.incap_cnt = incap_len(s_q.shdn_r[PSC_POS_INCAPQ+:2]);
		end else if (!s_q.sleep_r[PSC_BIT_WAKE]) begin
			s_d.ref_cnt = '0;
			s_d.incap_cnt = '0;
		end
		// Software reset restores every register, leaving the bus alone
		if (s_q.sw_reset) begin
			s_d.sleep_r = PSC_RST_SLEEP;
			s_d.shdn_r = PSC_RST_SHDN;
			s_d.serial_r = PSC_RST_SERIAL;
			s_d.ref_cnt = '0;
			s_d.incap_cnt = '0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.scl_s1 <= 1'b1;
			s_q.scl_s2 <= 1'b1;
			s_q.scl_s3 <= 1'b1;
			s_q.sda_s1 <= 1'b1;
			s_q.sda_s2 <= 1'b1;
			s_q.sda_s3 <= 1'b1;
			s_q.st <= PSC_IDLE;
			s_q.sleep_r <= PSC_RST_SLEEP;
			s_q.shdn_r <= PSC_RST_SHDN;
			s_q.serial_r <= PSC_RST_SERIAL;
		end else begin
			s_q <= s_d;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Outputs; open-drain line only ever pulled low
	assign sda_o = 1'b0;
	assign sda_oe = s_q.sda_drive;
	assign power_cfg.analog_supply_select = s_q.sleep_r[PSC_BIT_SUPPLY];
	assign power_cfg.reference_fast_charge_time = s_q.sleep_r[PSC_POS_REFQ+:2];
	assign power_cfg.broadcast_address_enable = s_q.sleep_r[PSC_BIT_BCAST];
	assign power_cfg.wake_not_sleep = s_q.sleep_r[PSC_BIT_WAKE];
	assign power_cfg.input_cap_fast_charge_time = s_q.shdn_r[PSC_POS_INCAPQ+:2];
	assign serial_cfg = psc_serial_cfg_t'(s_q.serial_r);
	assign ref_charge_active = (s_q.ref_cnt != '0);
	assign input_cap_charge_active = (s_q.incap_cnt != '0);

	// Serial data lanes follow the live format fields
	psc_serial_tx u_tx (
		.clk(clk),
		.rst(rst),
		.cfg(serial_cfg),
		.wake(s_q.sleep_r[PSC_BIT_WAKE]),
		.bit_clock_pin(bit_clock_pin),
		.frame_sync_pin(frame_sync_pin),
		.slot_words(slot_words),
		.data_o(serial_data_o),
		.data_oe(serial_data_oe)
	);

endmodule : psc_config_top

// >>> tb/psc_chk.sv
// Port checker for the power and serial format config block
`timescale 1ns/1ps
module psc_chk
	import psc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input psc_power_cfg_t power_cfg,
	input psc_serial_cfg_t serial_cfg,
	input wire logic ref_charge_active,
	input wire logic input_cap_charge_active,
	input wire logic [1:0] serial_data_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	// Bus pin behaviour
	a_sda_open_drain: assert property (sda_o == 1'b0)
		else $error("sda output level not low");
	a_ack_stands: assert property ($rose(sda_oe) |-> sda_oe [*8])
		else $error("sda pull released too soon");
	// Field contents and charge timers
	a_format_not_reserved: assert property (serial_cfg.serial_protocol_select != 2'h3)
		else $error("reserved protocol code held");
	a_ref_charge_start: assert property ($rose(power_cfg.wake_not_sleep) |-> ##[1:3] ref_charge_active)
		else $error("reference charge did not start");
	a_incap_charge_start: assert property ($rose(power_cfg.wake_not_sleep) |-> ##[1:3] input_cap_charge_active)
		else $error("input cap charge did not start");
	a_sleep_stops_charge: assert property ($fell(power_cfg.wake_not_sleep) |-> ##2 !(ref_charge_active || input_cap_charge_active))
		else $error("charge still active in sleep");
	// Lane drive versus sleep and fill
	a_sleep_lanes_off: assert property ((!power_cfg.wake_not_sleep) [*2] |-> serial_data_oe == 2'h0)
		else $error("lane driven while asleep");
	a_fill_driven: assert property ((power_cfg.wake_not_sleep && !serial_cfg.fill_high_z) [*3] |-> serial_data_oe == 2'h3)
		else $error("lane released with zero fill");
	// Fields only move on bus activity
	a_cfg_quiet: assert property ($stable(scl_i) [*8] |-> $stable(serial_cfg) && $stable(power_cfg))
		else $error("config changed without bus clock");
endmodule : psc_chk
bind psc_config_top psc_chk i_chk (
	.clk(clk),
	.rst(rst),
	.scl_i(scl_i),
	.sda_o(sda_o),
	.sda_oe(sda_oe),
	.power_cfg(power_cfg),
	.serial_cfg(serial_cfg),
	.ref_charge_active(ref_charge_active),
	.input_cap_charge_active(input_cap_charge_active),
	.serial_data_oe(serial_data_oe)
);

// >>> tb/psc_host_model.sv
// Control bus host model: open-drain bits, bytes and register transfers
`timescale 1ns/1ps
module psc_host_model
	import psc_pkg::*;
(
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_low
);
	localparam int HALF = 16;
	// Bus idle at time zero
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	////////////////////////////////////////////////////////////
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask : tk
	// SDA moves only a few clocks after SCL fell, never beside the fall
	task automatic bit_io(input logic b, output logic r);
		tk(4);
		sda_low <= ~b;
		tk(HALF);
		scl <= 1'b1;
		tk(HALF);
		@(negedge clk);
		r = sda_line;
		@(posedge clk);
		scl <= 1'b0;
	endtask : bit_io
	// Start, also as repeated start
	task automatic start();
		tk(4);
		sda_low <= 1'b0;
		tk(HALF);
		scl <= 1'b1;
		tk(HALF);
		sda_low <= 1'b1;
		tk(HALF);
		scl <= 1'b0;
	endtask : start
	task automatic stop();
		tk(4);
		sda_low <= 1'b1;
		tk(HALF);
		scl <= 1'b1;
		tk(HALF);
		sda_low <= 1'b0;
		tk(HALF);
	endtask : stop
	// Byte MSB first plus ninth bit; low ack_o means acknowledged
	task automatic xfer(input logic [7:0] tx, input logic ack_i, output logic [7:0] rx,
		output logic ack_o);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(ack_i, ack_o);
	endtask : xfer
	////////////////////////////////////////////////////////////
	// Reserved bits kept at reset levels code 3 never sent
	function automatic logic [7:0] legal(input logic [7:0] ofs, input logic [7:0] d);
		case (ofs)
			PSC_OFS_SLEEP: legal = d & 8'h9D;
			PSC_OFS_SHDN: legal = {2'h0, d[5:4], 4'h5};
			PSC_OFS_SERIAL: legal = (d[7:6] == PSC_FMT_RESERVED) ? {PSC_FMT_TDM, d[5:0]} : d;
			default: legal = d;
		endcase
	endfunction : legal
	// Raw writes exist only for refusal scenarios
	task automatic wr(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d,
		input logic raw, output logic ack);
		logic [7:0] rx;
		logic [2:0] k;
		start();
		xfer({a, 1'b0}, 1'b1, rx, k[0]);
		xfer(ofs, 1'b1, rx, k[1]);
		xfer(raw ? d : legal(ofs, d), 1'b1, rx, k[2]);
		stop();
		ack = (k === 3'h0);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] ofs, output logic [7:0] d,
		output logic ack);
		logic [7:0] rx;
		logic [3:0] k;
		start();
		xfer({a, 1'b0}, 1'b1, rx, k[0]);
		xfer(ofs, 1'b1, rx, k[1]);
		start();
		xfer({a, 1'b1}, 1'b1, rx, k[2]);
		xfer(8'hFF, 1'b1, d, k[3]);
		stop();
		ack = (k[2:0] === 3'h0);
	endtask : rd
endmodule : psc_host_model

// >>> tb/tb_top.sv
// Self-checking bench for the power and serial format config block
`timescale 1ns/1ps
module tb_top
	import psc_pkg::*;
;
	localparam logic [6:0] DEV = 7'h48; // Arbitrary own address
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic scl, sda_low, sda_o, sda_oe, sda_w, ref_act, inc_act;
	logic bclk = 1'b0;
	logic fs = 1'b0;
	logic [1:0] sd_o, sd_oe;
	psc_power_cfg_t pwr;
	psc_serial_cfg_t ser;
	logic [3:0][31:0] words = {32'h0, 32'h5A3C_F069, 32'h0, 32'hA5C3_0F96};
	logic [31:0] cyc = 32'h0;
	logic [31:0] ref_n = 32'h0;
	logic [31:0] inc_n = 32'h0;
	int fail_count = 0;
	int checked = 0;
	// Pull-up wire, low if either party pulls
	assign sda_w = ~(sda_low | (sda_oe & ~sda_o));
	initial begin
		forever #2.5 clk = ~clk;
	end
	// Codes 2 and 3 keep their real lengths; the bench only sees them still running
	psc_config_top #(.DEVICE_ADDR(DEV), .REF_CYC0(25'd20), .REF_CYC1(25'd40),
		.INCAP_CYC0(25'd30), .INCAP_CYC1(25'd50)) i_dut (.clk(clk), .rst(rst), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .power_cfg(pwr), .serial_cfg(ser),
		.ref_charge_active(ref_act), .input_cap_charge_active(inc_act), .bit_clock_pin(bclk),
		.frame_sync_pin(fs), .slot_words(words), .serial_data_o(sd_o), .serial_data_oe(sd_oe));
	psc_host_model i_host (.clk(clk), .sda_line(sda_w), .scl(scl), .sda_low(sda_low));
	// Hang ceiling and charge flag meters
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (ref_act === 1'b1) ref_n <= ref_n + 1;
		if (inc_act === 1'b1) inc_n <= inc_n + 1;
		if (cyc == 32'd90000) begin
			fail_count++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] d;
		logic k;
		i_host.rd(a, ofs, d, k);
		chk(32'(d), 32'(exp));
		chk(32'(k), 32'h1);
	endtask : rchk
	task automatic w(input logic [7:0] ofs, input logic [7:0] d, input logic raw);
		logic k;
		i_host.wr(DEV, ofs, d, raw, k);
		chk(32'(k), 32'h1);
	endtask : w
	////////////////////////////////////////////////////////////
	task automatic t_reset();
		rchk(DEV, PSC_OFS_SLEEP, PSC_RST_SLEEP);
		rchk(DEV, PSC_OFS_SHDN, PSC_RST_SHDN);
		rchk(DEV, PSC_OFS_SERIAL, PSC_RST_SERIAL);
		chk(32'(sd_oe), 32'h0);
	endtask : t_reset
	// Every charge code, each restarted from sleep; supply bit toggled along
	task automatic t_charge();
		logic [1:0] c;
		logic [31:0] r0, i0;
		for (int k = 0; k < 4; k++) begin
			c = 2'(k);
			w(PSC_OFS_SHDN, {2'h0, c, 4'h5}, 1'b0);
			w(PSC_OFS_SLEEP, {3'h0, c, 3'h0}, 1'b0);
			r0 = ref_n;
			i0 = inc_n;
			w(PSC_OFS_SLEEP, {c[0], 2'h0, c, 3'h1}, 1'b0);
			repeat (120) @(posedge clk);
			if (k < 2) begin
				chk(ref_n - r0, 32'(20 + 20 * k));
				chk(inc_n - i0, 32'(30 + 20 * k));
			end else begin
				chk(32'(ref_act), 32'h1);
				chk(32'(inc_act), 32'h1);
			end
			chk(32'(pwr), 32'({c[0], c, 1'b0, 1'b1, c}));
		end
	endtask : t_charge
	// Read-only bits, broadcast address on and off, unmapped place, software reset
	task automatic t_reserved();
		logic [7:0] d;
		logic k;
		w(PSC_OFS_SLEEP, 8'hFF, 1'b1);
		rchk(DEV, PSC_OFS_SLEEP, 8'hFD);
		w(PSC_OFS_SHDN, 8'hFF, 1'b1);
		rchk(PSC_BCAST_ADDR, PSC_OFS_SHDN, 8'h3F);
		w(8'h03, 8'hAA, 1'b0);
		rchk(DEV, PSC_OFS_SLEEP, 8'hFD);
		w(PSC_OFS_SWRST, 8'h01, 1'b0);
		rchk(DEV, PSC_OFS_SHDN, PSC_RST_SHDN);
		// Broadcast off after reset: nobody answers, the wire reads all ones
		i_host.rd(PSC_BCAST_ADDR, PSC_OFS_SLEEP, d, k);
		chk(32'(d), 32'hFF);
		chk(32'(k), 32'h0);
	endtask : t_reserved
	// Each legal protocol, then the refused code, all while asleep
	task automatic t_format();
		logic [7:0] v [3] = '{8'h0E, 8'h53, 8'hAC};
		foreach (v[i]) begin
			w(PSC_OFS_SERIAL, v[i], 1'b0);
			chk(32'(ser), 32'(v[i]));
		end
		w(PSC_OFS_SERIAL, 8'hF5, 1'b1);
		rchk(DEV, PSC_OFS_SERIAL, 8'hB5);
	endtask : t_format
	// One left-justified 16-bit frame; inverted pins must look the same
	task automatic t_frame(input logic [7:0] cfg);
		logic [31:0] e;
		int j;
		w(PSC_OFS_SERIAL, cfg, 1'b0);
		@(posedge clk);
		bclk <= cfg[2];
		fs <= cfg[3];
		w(PSC_OFS_SLEEP, 8'h01, 1'b0);
		@(posedge clk);
		fs <= ~cfg[3];
		for (int i = 0; i < 20; i++) begin
			repeat (12) @(posedge clk);
			@(negedge clk);
			// A late launch edge shows each bit one sample later
			j = i - int'(cfg[1]);
			for (int g = 0; g < 2; g++) begin
				e = (j > 0 && j <= 16) ? 32'(words[2 * g][32 - j]) : 32'h0;
				if (j > 0) chk(32'(sd_oe[g]), (j <= 16) ? 32'h1 : 32'(!cfg[0]));
				if (j > 0 && sd_oe[g] === 1'b1) chk(32'(sd_o[g]), e);
			end
			@(posedge clk);
			bclk <= ~cfg[2];
			repeat (12) @(posedge clk);
			bclk <= cfg[2];
		end
		w(PSC_OFS_SLEEP, 8'h00, 1'b0);
	endtask : t_frame
	////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_reset();
		t_charge();
		t_reserved();
		t_format();
		t_frame(8'h80);
		t_frame(8'h8D);
		t_frame(8'h82);
		final_report();
	end
endmodule : tb_top
